// ==== diffserv_params.svh ====
// Purpose: Offsets, field layout, reset values and bus codes of the priority map
// Assumes: Included by its bare name wherever a value is needed
// Notes: Register indexes are word indexes; the byte address is four times the index
`ifndef DIFFSERV_PARAMS_SVH
`define DIFFSERV_PARAMS_SVH

`define DS_ADDR_WIDTH 12
`define DS_DATA_WIDTH 32
`define DS_REG_COUNT 16
`define DS_CODE_WIDTH 6
`define DS_PRIO_WIDTH 2
`define DS_MAP_WIDTH 128
`define DS_BYTE_RESET 8'h00

// Register indexes; the byte address on the bus is index times four
`define DS_IDX_00_03 8'h90
`define DS_IDX_04_07 8'h91
`define DS_IDX_08_0B 8'h92
`define DS_IDX_0C_0F 8'h93
`define DS_IDX_10_13 8'h94
`define DS_IDX_14_17 8'h95
`define DS_IDX_18_1B 8'h96
`define DS_IDX_1C_1F 8'h97
`define DS_IDX_20_23 8'h98
`define DS_IDX_24_27 8'h99
`define DS_IDX_28_2B 8'h9A
`define DS_IDX_2C_2F 8'h9B
`define DS_IDX_30_33 8'h9C
`define DS_IDX_34_37 8'h9D
`define DS_IDX_38_3B 8'h9E
`define DS_IDX_3C_3F 8'h9F

// The sixteen indexes share their upper four bits
`define DS_IDX_PAGE 6'h09
`define DS_TOS_CODE_MSB 7
`define DS_TOS_CODE_LSB 2

`define DS_RESP_OKAY 2'h0
`define DS_RESP_SLVERR 2'h2

`endif

// ==== diffserv_pkg.sv ====
// Purpose: Types shared by the priority map files
// Assumes: Nothing is imported; users write diffserv_pkg::name
// Notes: State codes are written out so a waveform reads the same everywhere
package diffserv_pkg;

   typedef enum logic [1:0] {
      WR_IDLE = 2'b00,
      WR_HAVE_ADDR = 2'b01,
      WR_HAVE_DATA = 2'b10,
      WR_RESP = 2'b11
   } wr_state_type;

   typedef enum logic [0:0] {
      RD_IDLE = 1'b0,
      RD_RESP = 1'b1
   } rd_state_type;

endpackage : diffserv_pkg

// ==== diffserv_map_byte.sv ====
// Purpose: One byte of the priority table, four 2-bit entries
// Assumes: Synchronous active-high reset on the core clock
// Notes: Written whole; partial field writes are not offered
`include "diffserv_params.svh"

module diffserv_map_byte (
   input wire logic clk,
   input wire logic reset,
   input wire logic write_en,
   input wire logic [7:0] write_data,
   output logic [7:0] value
);

   logic [7:0] next_value;

   always_comb begin
      next_value = write_en ? write_data : value;
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         value <= `DS_BYTE_RESET;
      end else begin
         value <= next_value;
      end
   end

endmodule : diffserv_map_byte

// ==== diffserv_priority_map.sv ====
// Purpose: DiffServ priority table with an AXI4-Lite register slave
// Assumes: TOS_VALID, TOS_BYTE and IS_IP come from logic on REF_CLK
// Notes: Priority appears one cycle after the request; reads return old data on a same-cycle write
//
// Implementation choice: register access over AXI4-Lite.
`include "diffserv_params.svh"

module diffserv_priority_map (
   input wire logic REF_CLK,
   input wire logic RESET,
   input wire logic AWVALID,
   output logic AWREADY,
   input wire logic [`DS_ADDR_WIDTH-1:0] AWADDR,
   input wire logic [2:0] AWPROT,
   input wire logic WVALID,
   output logic WREADY,
   input wire logic [`DS_DATA_WIDTH-1:0] WDATA,
   input wire logic [3:0] WSTRB,
   output logic BVALID,
   input wire logic BREADY,
   output logic [1:0] BRESP,
   input wire logic ARVALID,
   output logic ARREADY,
   input wire logic [`DS_ADDR_WIDTH-1:0] ARADDR,
   input wire logic [2:0] ARPROT,
   output logic RVALID,
   input wire logic RREADY,
   output logic [`DS_DATA_WIDTH-1:0] RDATA,
   output logic [1:0] RRESP,
   input wire logic TOS_VALID,
   input wire logic [7:0] TOS_BYTE,
   input wire logic IS_IP,
   output logic PRIO_VALID,
   output logic [`DS_PRIO_WIDTH-1:0] PRIO
);

   diffserv_pkg::wr_state_type wr_state;
   diffserv_pkg::wr_state_type next_wr_state;
   diffserv_pkg::rd_state_type rd_state;
   diffserv_pkg::rd_state_type next_rd_state;
   logic [`DS_ADDR_WIDTH-1:0] wr_addr;
   logic [`DS_ADDR_WIDTH-1:0] next_wr_addr;
   logic [7:0] wr_data;
   logic [7:0] next_wr_data;
   logic wr_strb;
   logic next_wr_strb;
   logic [1:0] next_bresp;
   logic [`DS_DATA_WIDTH-1:0] next_rdata;
   logic [1:0] next_rresp;
   logic next_prio_valid;
   logic [`DS_PRIO_WIDTH-1:0] next_prio;
   logic aw_fire;
   logic w_fire;
   logic wr_commit;
   logic [`DS_ADDR_WIDTH-1:0] commit_addr;
   logic [7:0] commit_data;
   logic commit_strb;
   logic commit_hit;
   logic [3:0] commit_reg;
   logic rd_hit;
   logic [`DS_CODE_WIDTH-1:0] code;
   logic [7:0] map_byte [`DS_REG_COUNT];
   logic [`DS_MAP_WIDTH-1:0] map_flat;

   // Table storage: one byte register per four codes
   genvar g;
   generate
      for (g = 0; g < `DS_REG_COUNT; g++) begin : gen_map
         diffserv_map_byte u_byte (
            .clk(REF_CLK),
            .reset(RESET),
            .write_en(commit_hit && commit_strb && (commit_reg == 4'(g))),
            .write_data(commit_data),
            .value(map_byte[g])
         );
         assign map_flat[g*8 +: 8] = map_byte[g];
      end
   endgenerate

   // Write channel: address and data may arrive in either order
   assign aw_fire = AWVALID && AWREADY;
   assign w_fire = WVALID && WREADY;
   assign AWREADY = (wr_state == diffserv_pkg::WR_IDLE) || (wr_state == diffserv_pkg::WR_HAVE_DATA);
   assign WREADY = (wr_state == diffserv_pkg::WR_IDLE) || (wr_state == diffserv_pkg::WR_HAVE_ADDR);
   assign BVALID = (wr_state == diffserv_pkg::WR_RESP);

   always_comb begin
      next_wr_state = wr_state;
      next_wr_addr = wr_addr;
      next_wr_data = wr_data;
      next_wr_strb = wr_strb;
      next_bresp = BRESP;
      wr_commit = 1'b0;
      commit_addr = aw_fire ? AWADDR : wr_addr;
      commit_data = w_fire ? WDATA[7:0] : wr_data;
      commit_strb = w_fire ? WSTRB[0] : wr_strb;
      if (aw_fire) begin
         next_wr_addr = AWADDR;
      end
      if (w_fire) begin
         next_wr_data = WDATA[7:0];
         next_wr_strb = WSTRB[0];
      end
      case (wr_state)
         diffserv_pkg::WR_IDLE: begin
            if (aw_fire && w_fire) begin
               wr_commit = 1'b1;
            end else if (aw_fire) begin
               next_wr_state = diffserv_pkg::WR_HAVE_ADDR;
            end else if (w_fire) begin
               next_wr_state = diffserv_pkg::WR_HAVE_DATA;
            end
         end
         diffserv_pkg::WR_HAVE_ADDR: begin
            wr_commit = w_fire;
         end
         diffserv_pkg::WR_HAVE_DATA: begin
            wr_commit = aw_fire;
         end
         diffserv_pkg::WR_RESP: begin
            if (BREADY) begin
               next_wr_state = diffserv_pkg::WR_IDLE;
            end
         end
         default: begin
            next_wr_state = diffserv_pkg::WR_IDLE;
         end
      endcase
      if (wr_commit) begin
         next_wr_state = diffserv_pkg::WR_RESP;
         next_bresp = commit_hit ? `DS_RESP_OKAY : `DS_RESP_SLVERR;
      end
   end

   // Only the sixteen table words answer; anything else gets a slave error
   assign commit_hit = wr_commit && (commit_addr[`DS_ADDR_WIDTH-1:6] == `DS_IDX_PAGE);
   assign commit_reg = commit_addr[5:2];

   always_ff @(posedge REF_CLK) begin
      if (RESET) begin
         wr_state <= diffserv_pkg::WR_IDLE;
         wr_addr <= '0;
         wr_data <= `DS_BYTE_RESET;
         wr_strb <= 1'b0;
         BRESP <= `DS_RESP_OKAY;
      end else begin
         wr_state <= next_wr_state;
         wr_addr <= next_wr_addr;
         wr_data <= next_wr_data;
         wr_strb <= next_wr_strb;
         BRESP <= next_bresp;
      end
   end

   // Read channel: data captured when the address is taken
   assign ARREADY = (rd_state == diffserv_pkg::RD_IDLE);
   assign RVALID = (rd_state == diffserv_pkg::RD_RESP);
   assign rd_hit = (ARADDR[`DS_ADDR_WIDTH-1:6] == `DS_IDX_PAGE);

   always_comb begin
      next_rd_state = rd_state;
      next_rdata = RDATA;
      next_rresp = RRESP;
      case (rd_state)
         diffserv_pkg::RD_IDLE: begin
            if (ARVALID) begin
               next_rd_state = diffserv_pkg::RD_RESP;
               next_rdata = rd_hit ? {24'h000000, map_byte[ARADDR[5:2]]} : '0;
               next_rresp = rd_hit ? `DS_RESP_OKAY : `DS_RESP_SLVERR;
            end
         end
         diffserv_pkg::RD_RESP: begin
            if (RREADY) begin
               next_rd_state = diffserv_pkg::RD_IDLE;
            end
         end
         default: begin
            next_rd_state = diffserv_pkg::RD_IDLE;
         end
      endcase
   end

   always_ff @(posedge REF_CLK) begin
      if (RESET) begin
         rd_state <= diffserv_pkg::RD_IDLE;
         RDATA <= '0;
         RRESP <= `DS_RESP_OKAY;
      end else begin
         rd_state <= next_rd_state;
         RDATA <= next_rdata;
         RRESP <= next_rresp;
      end
   end

   // Lookup: no IP version input, so IPv4 and IPv6 cannot diverge
   assign code = TOS_BYTE[`DS_TOS_CODE_MSB:`DS_TOS_CODE_LSB];

   always_comb begin
      next_prio_valid = TOS_VALID && IS_IP;
      next_prio = PRIO;
      if (TOS_VALID && IS_IP) begin
         next_prio = map_flat[{code, 1'b0} +: `DS_PRIO_WIDTH];
      end
   end

   always_ff @(posedge REF_CLK) begin
      if (RESET) begin
         PRIO_VALID <= 1'b0;
         PRIO <= '0;
      end else begin
         PRIO_VALID <= next_prio_valid;
         PRIO <= next_prio;
      end
   end

   default clocking cb @(posedge REF_CLK);
   endclocking
   default disable iff (RESET);

   sequence s_ip_req(logic [5:0] c);
      TOS_VALID && IS_IP && (TOS_BYTE[7:2] == c);
   endsequence

   sequence s_write_to(logic [3:0] r);
      wr_commit && commit_hit && commit_strb && (commit_reg == r);
   endsequence

   a_ip_gives_prio: assert property (TOS_VALID && IS_IP |=> PRIO_VALID)
      else $error("IP request gave no priority");

   a_non_ip_ignored: assert property (TOS_VALID && !IS_IP |=> !PRIO_VALID)
      else $error("Non-IP request was classified");

   a_code_zero_map: assert property (s_ip_req(6'h00) |=> PRIO == $past(map_byte[0][1:0]))
      else $error("Code 0x00 not from bits 1-0 of the first byte");

   a_code_one_map: assert property (s_ip_req(6'h01) |=> PRIO == $past(map_byte[0][3:2]))
      else $error("Code 0x01 not from bits 3-2 of the first byte");

   a_code_two_three: assert property ((s_ip_req(6'h03) |=> PRIO == $past(map_byte[0][7:6]))
      and (s_ip_req(6'h02) |=> PRIO == $past(map_byte[0][5:4])))
      else $error("Code 0x02 or 0x03 from wrong field");

   a_code_four_map: assert property (s_ip_req(6'h04) |=> PRIO == $past(map_byte[1][1:0]))
      else $error("Code 0x04 not from bits 1-0 of the second byte");

   a_code_30_37: assert property ((s_ip_req(6'h30) |=> PRIO == $past(map_byte[12][1:0]))
      and (s_ip_req(6'h37) |=> PRIO == $past(map_byte[13][7:6])))
      else $error("Code 0x30 or 0x37 from wrong register");

   a_code_1f_map: assert property (s_ip_req(6'h1F) |=> PRIO == $past(map_byte[7][7:6]))
      else $error("Code 0x1F not from bits 7-6 of the eighth byte");

   a_write_stored: assert property (s_write_to(4'h5) ##1 !s_write_to(4'h5) |-> map_byte[5] == $past(commit_data))
      else $error("Table write not stored");

   a_write_resp: assert property (wr_commit |=> BVALID ##0 (BRESP == $past(commit_hit ? 2'h0 : 2'h2)))
      else $error("Write response missing or wrong");

   a_read_back: assert property (ARVALID && ARREADY && rd_hit && !wr_commit
      |=> RVALID && RDATA[7:0] == $past(map_byte[ARADDR[5:2]]) && RDATA[31:8] == 24'h000000)
      else $error("Table read returned wrong byte");

   a_reset_clears: assert property (disable iff (1'b0) RESET |=> map_flat == '0)
      else $error("Table not cleared by reset");

endmodule : diffserv_priority_map

// ==== diffserv_priority_map_tb_top.sv ====
// Purpose: Self-checking bench for the priority table and its register slave
// Assumes: One core clock; bus master and lookup requests driven from here
// Notes: Protection inputs are tied low since the slave ignores them
`include "diffserv_params.svh"

module diffserv_priority_map_tb_top;
   timeunit 1ns;
   timeprecision 100ps;

   logic ref_clk = 1'b0;
   logic reset = 1'b1;
   logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
   logic awready, wready, bvalid, arready, rvalid, prio_valid;
   logic [`DS_ADDR_WIDTH-1:0] awaddr = '0, araddr = '0;
   logic [`DS_DATA_WIDTH-1:0] wdata = '0, rdata;
   logic [3:0] wstrb = 4'h0;
   logic [1:0] bresp, rresp;
   logic tos_valid = 1'b0, is_ip = 1'b0;
   logic [7:0] tos_byte = 8'h00;
   logic [`DS_PRIO_WIDTH-1:0] prio;
   logic [7:0] table_image [16];
   int n_errors = 0;
   int total_checks = 0;

   always #5 ref_clk = ~ref_clk;

   diffserv_priority_map diffserv_priority_map_inst (.REF_CLK(ref_clk), .RESET(reset), .AWVALID(awvalid),
      .AWREADY(awready), .AWADDR(awaddr), .AWPROT(3'h0), .WVALID(wvalid), .WREADY(wready), .WDATA(wdata),
      .WSTRB(wstrb), .BVALID(bvalid), .BREADY(bready), .BRESP(bresp), .ARVALID(arvalid), .ARREADY(arready),
      .ARADDR(araddr), .ARPROT(3'h0), .RVALID(rvalid), .RREADY(rready), .RDATA(rdata), .RRESP(rresp),
      .TOS_VALID(tos_valid), .TOS_BYTE(tos_byte), .IS_IP(is_ip), .PRIO_VALID(prio_valid), .PRIO(prio));

   task automatic compare(input logic [31:0] got, input logic [31:0] exp, input string what);
      total_checks++;
      if (got !== exp) begin
         n_errors++;
         $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
      end
   endtask : compare

   // Address and data offered together; each released at its own handshake
   task automatic bus_write(input logic [11:0] addr, input logic [7:0] data, input logic [3:0] strb,
                            input logic [1:0] exp_resp);
      int k;
      @(posedge ref_clk);
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      awaddr <= addr;
      wdata <= {24'h000000, data};
      wstrb <= strb;
      bready <= 1'b1;
      for (k = 0; k < 64 && (awvalid || wvalid); k++) begin
         @(posedge ref_clk);
         if (awvalid && awready) awvalid <= 1'b0;
         if (wvalid && wready) wvalid <= 1'b0;
      end
      for (k = 0; k < 64 && !bvalid; k++) @(posedge ref_clk);
      bready <= 1'b0;
      compare({30'h0, bresp}, {30'h0, exp_resp}, "write response");
   endtask : bus_write

   task automatic bus_read(input logic [11:0] addr, input logic [31:0] exp_data, input logic [1:0] exp_resp);
      int k;
      @(posedge ref_clk);
      arvalid <= 1'b1;
      araddr <= addr;
      rready <= 1'b1;
      for (k = 0; k < 64 && arvalid; k++) begin
         @(posedge ref_clk);
         if (arready) arvalid <= 1'b0;
      end
      for (k = 0; k < 64 && !rvalid; k++) @(posedge ref_clk);
      rready <= 1'b0;
      compare(rdata, exp_data, "read data");
      compare({30'h0, rresp}, {30'h0, exp_resp}, "read response");
   endtask : bus_read

   // Result is sampled exactly one cycle after the request is taken
   task automatic lookup(input logic [7:0] tos, input logic ip, input logic [1:0] exp_prio);
      @(posedge ref_clk);
      tos_valid <= 1'b1;
      tos_byte <= tos;
      is_ip <= ip;
      @(posedge ref_clk);
      tos_valid <= 1'b0;
      @(posedge ref_clk);
      compare({31'h0, prio_valid}, {31'h0, ip}, "lookup valid");
      compare({30'h0, prio}, {30'h0, exp_prio}, "lookup priority");
   endtask : lookup

   task automatic test_reset_values;
      for (int i = 0; i < 16; i++) bus_read(12'h240 + 12'(4 * i), 32'h0, `DS_RESP_OKAY);
      lookup(8'hFC, 1'b1, 2'h0);
   endtask : test_reset_values

   // Distinct byte per register so a wrong register or field shows up
   task automatic test_full_map;
      logic [7:0] b;
      for (int i = 0; i < 16; i++) begin
         table_image[i] = 8'(i * 29 + 8'h6C);
         bus_write(12'h240 + 12'(4 * i), table_image[i], 4'h1, `DS_RESP_OKAY);
         bus_read(12'h240 + 12'(4 * i), {24'h0, table_image[i]}, `DS_RESP_OKAY);
      end
      for (int n = 0; n < 64; n++) begin
         b = table_image[n / 4];
         lookup({6'(n), 2'(n) ^ 2'h3}, 1'b1, b[2 * (n % 4) +: 2]);
      end
   endtask : test_full_map

   task automatic test_non_ip;
      logic [7:0] b;
      b = table_image[12];
      lookup(8'hC0, 1'b1, b[1:0]);
      lookup(8'h08, 1'b0, b[1:0]);
      b = table_image[13];
      lookup(8'hDE, 1'b1, b[7:6]);
   endtask : test_non_ip

   task automatic test_bus_refusals;
      bus_write(12'h100, 8'hFF, 4'h1, `DS_RESP_SLVERR);
      bus_read(12'h100, 32'h0, `DS_RESP_SLVERR);
      bus_write(12'h240, 8'hFF, 4'h0, `DS_RESP_OKAY);
      bus_read(12'h240, {24'h0, table_image[0]}, `DS_RESP_OKAY);
      lookup(8'h00, 1'b1, table_image[0][1:0]);
   endtask : test_bus_refusals

   task automatic give_verdict;
      $display("checks %0d errors %0d", total_checks, n_errors);
      if (n_errors == 0 && total_checks > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask : give_verdict

   initial begin
      repeat (4) @(posedge ref_clk);
      reset <= 1'b0;
      @(posedge ref_clk);
      test_reset_values();
      test_full_map();
      test_non_ip();
      test_bus_refusals();
      give_verdict();
   end

   // Whole run needs under 2000 cycles
   initial begin
      repeat (20000) @(posedge ref_clk);
      n_errors++;
      give_verdict();
   end
endmodule : diffserv_priority_map_tb_top
